// >>> logic/flow_exec.sv
/*
  control-flow execution unit: indirect calls, skips and conditional
  relative branches, loaded and launched over an AHB-Lite slave.
  assumes single word transfers, one slave on the bus, hsel from decoder.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - indirect call loads pc[15:0] from z, clears pc[21:16], 2 or 3 cycles.
// - extended call takes pc[21:16] from extension reg, z below, 3 cycles.
// - compare-skip skips next instruction when both registers are equal.
// - register bit-clear skip skips when the chosen bit is 0.
// - register bit-set skip skips when the chosen bit is 1.
// - i/o bit-clear skip skips when the bit is 0, 2/3/4 cycles.
// - i/o bit-set skip skips when the bit is 1, 2/3/4 cycles.
// - flag-set branch jumps to pc plus offset plus one when flag s is 1.
// - flag-clear branch jumps when flag s is 0, else falls through.
// - carry branches jump on carry 1 (set) or carry 0 (clear).
// - same-or-higher jumps on carry 0, lower jumps on carry 1.
// - signed greater-or-equal jumps when negative xor overflow is 0.
// - signed less-than jumps when negative xor overflow is 1.
// - half-carry branches jump on half-carry 1 (set) or 0 (clear).
// - transfer-bit branches jump on transfer flag 1 (set) or 0 (clear).
// - overflow branches jump on overflow 1 (set) or 0 (clear).
// - interrupt-state branches jump on interrupt enable 1 or 0.
module flow_exec #(
  parameter bit long_call = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [21:0] prog_counter,
  output logic exec_busy
);

  typedef enum logic {st_idle, st_run} exec_state_t;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic dp_write, next_dp_write, next_hreadyout;
  logic [7:0] dp_addr, next_dp_addr;
  logic [31:0] next_hrdata, rd_mux;
  logic accept, data_phase, wr;

  // software-visible state
  logic [7:0] rd_val, rr_val, io_val, flags;
  logic [7:0] next_rd_val, next_rr_val, next_io_val, next_flags;
  logic [15:0] zptr, next_zptr;
  logic [5:0] ext_reg, next_ext_reg;

  // execution state
  exec_state_t state, next_state;
  logic [21:0] pc, next_pc, target, next_target;
  logic [2:0] cycles, next_cycles, cnt, next_cnt;
  logic skipped, next_skipped, taken, next_taken;
  logic [4:0] op;
  logic [2:0] bsel, ssel;
  logic [6:0] kfld;
  logic two_word, cond, launch;
  logic [21:0] pc_rel, pc_skip;

  assign accept = hsel && hready && htrans[1];
  assign data_phase = !hreadyout;
  assign wr = data_phase && dp_write;
  assign op = hwdata[flow_pkg::OP_LSB +: flow_pkg::OP_W];
  assign bsel = hwdata[flow_pkg::BIT_LSB +: flow_pkg::SEL_W];
  assign ssel = hwdata[flow_pkg::SSEL_LSB +: flow_pkg::SEL_W];
  assign kfld = hwdata[flow_pkg::K_LSB +: flow_pkg::K_W];
  assign two_word = hwdata[flow_pkg::TWO_WORD_BIT];
  assign launch = wr && dp_addr == flow_pkg::OFF_INSTR && state == st_idle
    && op <= flow_pkg::OP_BID;
  assign pc_rel = pc + {{15{kfld[6]}}, kfld} + flow_pkg::PC_STEP;
  assign pc_skip = two_word ? pc + flow_pkg::PC_SKIP2
    : pc + flow_pkg::PC_SKIP1;

  // read data for the word in its data phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (dp_addr)
      flow_pkg::OFF_OPND: rd_mux = {8'h00, io_val, rr_val, rd_val};
      flow_pkg::OFF_FLAGS: rd_mux = {24'h00_0000, flags};
      flow_pkg::OFF_ZPTR: rd_mux = {16'h0000, zptr};
      flow_pkg::OFF_EXT: rd_mux = {26'h000_0000, ext_reg};
      flow_pkg::OFF_PC: rd_mux = {10'h000, pc};
      flow_pkg::OFF_STATUS: begin
        rd_mux[flow_pkg::ST_BUSY] = state == st_run;
        rd_mux[flow_pkg::ST_SKIP] = skipped;
        rd_mux[flow_pkg::ST_TAKEN] = taken;
        rd_mux[flow_pkg::ST_CYC_LSB +: flow_pkg::CYC_W] = cycles;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state per transfer, then answer
  always_comb begin
    next_hreadyout = hreadyout;
    next_dp_write = dp_write;
    next_dp_addr = dp_addr;
    next_hrdata = hrdata;
    if (data_phase) begin
      next_hreadyout = 1'b1;
      if (!dp_write) begin
        next_hrdata = rd_mux;
      end
    end else if (accept) begin
      next_hreadyout = 1'b0;
      next_dp_write = hwrite;
      next_dp_addr = haddr[7:0];
    end
  end

  // operand registers written by software
  always_comb begin
    next_rd_val = rd_val;
    next_rr_val = rr_val;
    next_io_val = io_val;
    next_flags = flags;
    next_zptr = zptr;
    next_ext_reg = ext_reg;
    if (wr) begin
      case (dp_addr)
        flow_pkg::OFF_OPND: begin
          next_rd_val = hwdata[flow_pkg::RD_LSB +: 8];
          next_rr_val = hwdata[flow_pkg::RR_LSB +: 8];
          next_io_val = hwdata[flow_pkg::IO_LSB +: 8];
        end
        flow_pkg::OFF_FLAGS: next_flags = hwdata[7:0];
        flow_pkg::OFF_ZPTR: next_zptr = hwdata[flow_pkg::Z_W-1:0];
        flow_pkg::OFF_EXT: next_ext_reg = hwdata[flow_pkg::EXT_W-1:0];
        default: next_flags = flags;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // instruction condition
  // ----------------------------------------------------------------------
  always_comb begin
    cond = 1'b0;
    case (op)
      flow_pkg::OP_EQ_SKIP: cond = rd_val == rr_val;
      flow_pkg::OP_SRBC: cond = !rd_val[bsel];
      flow_pkg::OP_SRBS: cond = rd_val[bsel];
      flow_pkg::OP_SIOC: cond = !io_val[bsel];
      flow_pkg::OP_SIOS: cond = io_val[bsel];
      flow_pkg::OP_BFS: cond = flags[ssel];
      flow_pkg::OP_BFC: cond = !flags[ssel];
      flow_pkg::OP_BCS: cond = flags[flow_pkg::FL_C];
      flow_pkg::OP_BCC: cond = !flags[flow_pkg::FL_C];
      flow_pkg::OP_BUGE: cond = !flags[flow_pkg::FL_C];
      flow_pkg::OP_BULT: cond = flags[flow_pkg::FL_C];
      flow_pkg::OP_BSGE:
        cond = !(flags[flow_pkg::FL_N] ^ flags[flow_pkg::FL_V]);
      flow_pkg::OP_BSLT:
        cond = flags[flow_pkg::FL_N] ^ flags[flow_pkg::FL_V];
      flow_pkg::OP_BHS: cond = flags[flow_pkg::FL_H];
      flow_pkg::OP_BHC: cond = !flags[flow_pkg::FL_H];
      flow_pkg::OP_BTS: cond = flags[flow_pkg::FL_T];
      flow_pkg::OP_BTC: cond = !flags[flow_pkg::FL_T];
      flow_pkg::OP_BVS: cond = flags[flow_pkg::FL_V];
      flow_pkg::OP_BVC: cond = !flags[flow_pkg::FL_V];
      flow_pkg::OP_BIE: cond = flags[flow_pkg::FL_I];
      flow_pkg::OP_BID: cond = !flags[flow_pkg::FL_I];
      default: cond = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // execution: target and cycle count fixed at launch, pc at the end
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_target = target;
    next_cycles = cycles;
    next_cnt = cnt;
    next_skipped = skipped;
    next_taken = taken;
    case (state)
      st_idle: begin
        if (wr && dp_addr == flow_pkg::OFF_PC) begin
          next_pc = hwdata[flow_pkg::PC_W-1:0];
        end
        if (launch) begin
          next_state = st_run;
          next_skipped = 1'b0;
          next_taken = 1'b0;
          if (op == flow_pkg::OP_IND_CALL) begin
            next_target = {6'h00, zptr};
            next_cycles = long_call ? flow_pkg::CYC_CALL_LONG
              : flow_pkg::CYC_CALL;
          end else if (op == flow_pkg::OP_EXT_CALL) begin
            next_target = {ext_reg, zptr};
            next_cycles = flow_pkg::CYC_EXT_CALL;
          end else if (op <= flow_pkg::OP_SIOS) begin
            next_skipped = cond;
            next_target = cond ? pc_skip : pc + flow_pkg::PC_STEP;
            next_cycles = !cond ? flow_pkg::CYC_ONE
              : two_word ? flow_pkg::CYC_THREE : flow_pkg::CYC_TWO;
            if (op >= flow_pkg::OP_SIOC) begin
              next_cycles = next_cycles + flow_pkg::CYC_ONE;
            end
          end else begin
            next_taken = cond;
            next_target = cond ? pc_rel : pc + flow_pkg::PC_STEP;
            next_cycles = cond ? flow_pkg::CYC_TWO
              : flow_pkg::CYC_ONE;
          end
          next_cnt = next_cycles;
        end
      end
      st_run: begin
        next_cnt = cnt - flow_pkg::CYC_ONE;
        if (cnt == flow_pkg::CYC_ONE) begin
          next_pc = target;
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  // register all state; clk_en low freezes everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      rd_val <= 8'h00;
      rr_val <= 8'h00;
      io_val <= 8'h00;
      flags <= 8'h00;
      zptr <= 16'h0000;
      ext_reg <= 6'h00;
      state <= st_idle;
      pc <= 22'h00_0000;
      target <= 22'h00_0000;
      cycles <= 3'h0;
      cnt <= 3'h0;
      skipped <= 1'b0;
      taken <= 1'b0;
      exec_busy <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      rd_val <= next_rd_val;
      rr_val <= next_rr_val;
      io_val <= next_io_val;
      flags <= next_flags;
      zptr <= next_zptr;
      ext_reg <= next_ext_reg;
      state <= next_state;
      pc <= next_pc;
      target <= next_target;
      cycles <= next_cycles;
      cnt <= next_cnt;
      skipped <= next_skipped;
      taken <= next_taken;
      exec_busy <= next_state == st_run;
    end
  end

  assign prog_counter = pc;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  call_target_a: assert property (
    clk_en && launch && op == flow_pkg::OP_IND_CALL |=>
      target == {6'h00, $past(zptr)} && cycles == (long_call ? 3'h3 : 3'h2))
    else $error("indirect call target or length wrong");
  ext_call_target_a: assert property (
    clk_en && launch && op == flow_pkg::OP_EXT_CALL |=>
      target == {$past(ext_reg), $past(zptr)} && cycles == 3'h3)
    else $error("extended indirect call target or length wrong");
  equal_skip_a: assert property (
    clk_en && launch && op == flow_pkg::OP_EQ_SKIP && rd_val == rr_val
      && !two_word |=> skipped && target == $past(pc) + 22'h00_0002)
    else $error("equal compare did not skip one word");
  reg_clear_a: assert property (
    clk_en && launch && op == flow_pkg::OP_SRBC |=>
      skipped == !$past(rd_val[bsel]))
    else $error("register bit-clear skip wrong");
  reg_set_a: assert property (
    clk_en && launch && op == flow_pkg::OP_SRBS && two_word && rd_val[bsel]
      |=> cycles == 3'h3 && target == $past(pc) + 22'h00_0003)
    else $error("register bit-set skip over two words wrong");
  io_clear_a: assert property (
    clk_en && launch && op == flow_pkg::OP_SIOC && !io_val[bsel] && two_word
      |=> cycles == 3'h4)
    else $error("i/o bit-clear skip length wrong");
  io_set_a: assert property (
    clk_en && launch && op == flow_pkg::OP_SIOS && !io_val[bsel] |=>
      !skipped && cycles == 3'h2)
    else $error("i/o bit-set no-skip length wrong");
  flag_set_a: assert property (
    clk_en && launch && op == flow_pkg::OP_BFS && flags[ssel] |=>
      taken && target == $past(pc) + {{15{$past(kfld[6])}}, $past(kfld)}
      + 22'h00_0001)
    else $error("flag-set branch target wrong");
  flag_clear_a: assert property (
    clk_en && launch && op == flow_pkg::OP_BFC && flags[ssel] |=>
      !taken && target == $past(pc) + 22'h00_0001)
    else $error("flag-clear branch did not fall through");
  branch_len_a: assert property (
    clk_en && launch && op >= flow_pkg::OP_BFS |=>
      cycles == (taken ? 3'h2 : 3'h1))
    else $error("branch cycle count wrong");
  pc_commit_a: assert property (
    clk_en && state == st_run && cnt == 3'h1 |=> pc == $past(target)
      && !exec_busy)
    else $error("pc not committed at end of instruction");

endmodule // flow_exec

// >>> logic/flow_pkg.sv
/*
  constants for the control-flow execution block: bus offsets, instruction
  word fields, opcode values, flag positions and cycle counts.
  assumes a 32-bit AHB-Lite register bus and a 22-bit program counter.
*/
package flow_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_OPND = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_ZPTR = 8'h0C;
  localparam logic [7:0] OFF_EXT = 8'h10;
  localparam logic [7:0] OFF_PC = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ----------------------------------------------------------------------
  // instruction word and operand fields
  // ----------------------------------------------------------------------
  localparam int OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int BIT_LSB = 5;
  localparam int SSEL_LSB = 8;
  localparam int SEL_W = 3;
  localparam int K_LSB = 16;
  localparam int K_W = 7;
  localparam int TWO_WORD_BIT = 24;
  localparam int RD_LSB = 0;
  localparam int RR_LSB = 8;
  localparam int IO_LSB = 16;
  localparam int PC_W = 22;
  localparam int Z_W = 16;
  localparam int EXT_W = 6;
  localparam int CYC_W = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_SKIP = 1;
  localparam int ST_TAKEN = 2;
  localparam int ST_CYC_LSB = 4;

  // ----------------------------------------------------------------------
  // core flag register bit positions
  // ----------------------------------------------------------------------
  localparam int FL_C = 0;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  // ----------------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------------
  localparam logic [4:0] OP_IND_CALL = 5'h00;
  localparam logic [4:0] OP_EXT_CALL = 5'h01;
  localparam logic [4:0] OP_EQ_SKIP = 5'h02;
  localparam logic [4:0] OP_SRBC = 5'h03;
  localparam logic [4:0] OP_SRBS = 5'h04;
  localparam logic [4:0] OP_SIOC = 5'h05;
  localparam logic [4:0] OP_SIOS = 5'h06;
  localparam logic [4:0] OP_BFS = 5'h07;
  localparam logic [4:0] OP_BFC = 5'h08;
  localparam logic [4:0] OP_BCS = 5'h09;
  localparam logic [4:0] OP_BCC = 5'h0A;
  localparam logic [4:0] OP_BUGE = 5'h0B;
  localparam logic [4:0] OP_BULT = 5'h0C;
  localparam logic [4:0] OP_BSGE = 5'h0D;
  localparam logic [4:0] OP_BSLT = 5'h0E;
  localparam logic [4:0] OP_BHS = 5'h0F;
  localparam logic [4:0] OP_BHC = 5'h10;
  localparam logic [4:0] OP_BTS = 5'h11;
  localparam logic [4:0] OP_BTC = 5'h12;
  localparam logic [4:0] OP_BVS = 5'h13;
  localparam logic [4:0] OP_BVC = 5'h14;
  localparam logic [4:0] OP_BIE = 5'h15;
  localparam logic [4:0] OP_BID = 5'h16;

  // ----------------------------------------------------------------------
  // cycle counts and pc steps
  // ----------------------------------------------------------------------
  localparam logic [2:0] CYC_CALL = 3'h2;
  localparam logic [2:0] CYC_CALL_LONG = 3'h3;
  localparam logic [2:0] CYC_EXT_CALL = 3'h3;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [21:0] PC_STEP = 22'h00_0001;
  localparam logic [21:0] PC_SKIP1 = 22'h00_0002;
  localparam logic [21:0] PC_SKIP2 = 22'h00_0003;

endpackage

// >>> test/test_branch_skip_call_control.sv
/*
  self-checking bench for flow_exec: indirect calls, skips and relative
  branches launched over the register bus, results read back as status.
  assumes flow_pkg and flow_exec are compiled first; one slave on the bus.
*/
`timescale 1ns/1ps
`define CHECK(nm, ex, gt) begin \
  samples_checked++; \
  if ((gt) !== (ex)) begin \
    error_cnt++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
  end \
end

module test_branch_skip_call_control;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic clk_en = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic exec_busy;
  logic [31:0] hrdata;
  logic [21:0] prog_counter;
  int error_cnt = 0;
  int samples_checked = 0;

  // --------------------------------------------------------------------
  // clock and design
  // --------------------------------------------------------------------
  always #20 hclk = ~hclk;

  flow_exec flow_exec_inst (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .prog_counter(prog_counter),
    .exec_busy(exec_busy)
  );

  // --------------------------------------------------------------------
  // bus and execution helpers
  // --------------------------------------------------------------------
  // verdict and end of run
  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    if (hreadyout !== 1'h1) begin
      error_cnt++;
      $display("mismatch hready expected 1 seen %b", hreadyout);
      results();
    end
  endtask

  // one single word transfer, address phase then data phase
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
  endtask

  // instruction word from its fields
  function automatic logic [31:0] mk(input logic [4:0] op,
      input logic [2:0] b, input logic [2:0] s, input logic [6:0] k,
      input logic two);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[4:0] = op;
    w[7:5] = b;
    w[10:8] = s;
    w[22:16] = k;
    w[24] = two;
    return w;
  endfunction

  // branch outcome from opcode number and flag byte
  function automatic logic br_taken(input int op, input logic [7:0] f,
                                    input logic [2:0] s);
    case (op)
      7: return f[s];
      8: return !f[s];
      9, 12: return f[0];
      10, 11: return !f[0];
      13: return !(f[2] ^ f[3]);
      14: return f[2] ^ f[3];
      15: return f[5];
      16: return !f[5];
      17: return f[6];
      18: return !f[6];
      19: return f[3];
      20: return !f[3];
      21: return f[7];
      default: return !f[7];
    endcase
  endfunction

  // launch from pc0, count busy cycles, then read status
  task automatic run(input logic [21:0] pc0, input logic [31:0] instr,
      output logic [21:0] pc, output int cyc, output logic [31:0] st);
    int n;
    wr(flow_pkg::OFF_PC, {10'h000, pc0});
    wr(flow_pkg::OFF_INSTR, instr);
    cyc = 1;
    n = 0;
    while (n < 20) begin
      @(posedge hclk);
      n++;
      if (exec_busy !== 1'h1) break;
      cyc++;
    end
    if (exec_busy !== 1'h0) begin
      error_cnt++;
      $display("mismatch exec_busy expected 0 seen %b", exec_busy);
      results();
    end
    pc = prog_counter;
    xfer(1'h0, flow_pkg::OFF_STATUS, 32'h0000_0000, st);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  // both indirect calls from a pc with high bits set
  task automatic calls_scn;
    logic [21:0] pc;
    int cyc;
    logic [31:0] st;
    wr(flow_pkg::OFF_ZPTR, 32'h0000_BEEF);
    wr(flow_pkg::OFF_EXT, 32'h0000_002A);
    run(22'h3F_0123, mk(flow_pkg::OP_IND_CALL, 3'h0, 3'h0, 7'h00, 1'h0),
        pc, cyc, st);
    `CHECK("call pc", 22'h00_BEEF, pc)
    `CHECK("call cycles", 2, cyc)
    run(22'h3F_0123, mk(flow_pkg::OP_EXT_CALL, 3'h0, 3'h0, 7'h00, 1'h0),
        pc, cyc, st);
    `CHECK("ext call pc", 22'h2A_BEEF, pc)
    `CHECK("ext call cycles", 3, cyc)
    xfer(1'h0, flow_pkg::OFF_ZPTR, 32'h0000_0000, st);
    `CHECK("z readback", 32'h0000_BEEF, st)
    xfer(1'h0, flow_pkg::OFF_EXT, 32'h0000_0000, st);
    `CHECK("ext readback", 32'h0000_002A, st)
  endtask

  // every skip kind, condition true and false, one and two word follower
  task automatic skip_scn;
    logic [4:0] ops [5];
    logic [21:0] pc;
    logic [21:0] exp_pc;
    int cyc;
    int ecyc;
    int i;
    logic [31:0] st;
    logic v;
    logic t;
    logic sk;
    logic skf;
    ops = '{flow_pkg::OP_EQ_SKIP, flow_pkg::OP_SRBC, flow_pkg::OP_SRBS,
            flow_pkg::OP_SIOC, flow_pkg::OP_SIOS};
    for (int n = 0; n < 20; n++) begin
      i = n / 4;
      v = n[1];
      t = n[0];
      // bit 5 of every bit-skip operand equals v; compare operands differ if v=0
      wr(flow_pkg::OFF_OPND, v ? 32'h0020_2020 :
         (i == 0 ? 32'h0000_2021 : 32'h0000_0000));
      sk = (i == 1 || i == 3) ? !v : v;
      exp_pc = 22'h00_0100 + (sk ? 22'h00_0002 + 22'(t) : 22'h00_0001);
      ecyc = (sk ? 2 + int'(t) : 1) + int'(i > 2);
      run(22'h00_0100, mk(ops[i], 3'h5, 3'h0, 7'h00, t), pc, cyc, st);
      skf = st[flow_pkg::ST_SKIP];
      `CHECK("skip pc", exp_pc, pc)
      `CHECK("skip cycles", ecyc, cyc)
      `CHECK("skip flag", sk, skf)
    end
  endtask

  // clk_en low in mid-instruction holds busy and pc until it returns
  task automatic freeze_scn;
    wr(flow_pkg::OFF_FLAGS, 32'h0000_0001);
    wr(flow_pkg::OFF_PC, 32'h0000_0300);
    wr(flow_pkg::OFF_INSTR, mk(flow_pkg::OP_BCS, 3'h0, 3'h0, 7'h04, 1'h0));
    clk_en <= 1'h0;
    repeat (4) @(posedge hclk);
    `CHECK("frozen busy", 1'h1, exec_busy)
    `CHECK("frozen pc", 22'h00_0300, prog_counter)
    clk_en <= 1'h1;
    repeat (2) @(posedge hclk);
    `CHECK("resumed busy", 1'h0, exec_busy)
    `CHECK("resumed pc", 22'h00_0305, prog_counter)
  endtask

  // every branch opcode against four flag patterns, both offset signs
  task automatic branch_scn;
    logic [7:0] fl [4];
    logic [21:0] pc;
    logic [21:0] exp_pc;
    int cyc;
    logic [31:0] st;
    logic tk;
    logic [6:0] k;
    logic [2:0] s;
    fl = '{8'h00, 8'hFF, 8'h08, 8'h04};
    for (int op = 7; op <= 22; op++) begin
      for (int j = 0; j < 4; j++) begin
        k = j[0] ? 7'h7D : 7'h05;
        s = 3'(op + j);
        wr(flow_pkg::OFF_FLAGS, {24'h00_0000, fl[j]});
        tk = br_taken(op, fl[j], s);
        exp_pc = tk ? 22'h00_0201 + {{15{k[6]}}, k} : 22'h00_0201;
        run(22'h00_0200, mk(5'(op), 3'h0, s, k, 1'h0), pc, cyc, st);
        if (op < 11) `CHECK("branch pc", exp_pc, pc)
        else if (op < 15) `CHECK("branch pc", exp_pc, pc)
        else `CHECK("branch pc", exp_pc, pc)
        `CHECK("branch cycles", tk ? 2 : 1, cyc)
        `CHECK("branch taken", tk, st[flow_pkg::ST_TAKEN])
      end
    end
  endtask

  // read of an unmapped offset returns zero with an okay answer
  task automatic bus_scn;
    logic [31:0] q;
    xfer(1'h0, 8'h40, 32'h0000_0000, q);
    `CHECK("unmapped read", 32'h0000_0000, q)
    `CHECK("hresp", 1'h0, hresp)
  endtask

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    calls_scn();
    skip_scn();
    branch_scn();
    freeze_scn();
    bus_scn();
    results();
  end
endmodule // test_branch_skip_call_control
